// *** core/refctl_consts.svh ***
// Offsets, field positions, reset values and timing counts of the reference control block
`ifndef REFCTL_CONSTS_SVH
`define REFCTL_CONSTS_SVH
`define REF_CTRL_OFFSET 4'h0
`define REF_IRQ_STATUS_OFFSET 4'h4
`define REF_IRQ_MASK_OFFSET 4'h8
`define REF_OPTIONS_OFFSET 4'hc
`define REF_EN_BIT 7
`define REF_RDY_BIT 6
`define TS_EN_BIT 5
`define TS_RNG_BIT 4
`define CMP_GAIN_HI 3
`define CMP_GAIN_LO 2
`define ADC_GAIN_HI 1
`define ADC_GAIN_LO 0
`define REF_CTRL_RESET 8'h00
`define REF_CTRL_WMASK 8'hbf
`define IRQ_READY_RISE_BIT 0
`define IRQ_READY_FALL_BIT 1
`define IRQ_BITS 2
`define SETTLE_TIME_US 25
`define CLOCK_MHZ 40
`define SETTLE_CYCLES ((`SETTLE_TIME_US) * (`CLOCK_MHZ))
`endif

// *** core/refctl_pkg.sv ***
// Types shared by the reference control block
package refctl_pkg;
   typedef enum logic [1:0] {gain_off, gain_x1, gain_x2, gain_x4} gain_e;
   typedef enum {ref_off, ref_settling, ref_ready} ref_state_e;
endpackage

// *** core/settle_timer.sv ***
// Settling counter for the fixed reference and its amplifier
`timescale 1ns/100ps
`default_nettype none
module settle_timer #(
   parameter int unsigned CYCLES = 1000
) (
   input wire logic clock, // Core clock
   input wire logic rstn, // Async reset, active low
   input wire logic run, // Count while high, clear when low
   output logic done // High once CYCLES counted
);
   logic [31:0] count_r;
   wire at_end = (count_r >= CYCLES - 1);
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         count_r <= 32'h0;
      else if (!run)
         count_r <= 32'h0;
      else if (!at_end)
         count_r <= count_r + 32'h1;
   end
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         done <= 1'b0;
      else
         done <= run && at_end;
   end
endmodule // settle_timer
`default_nettype wire

// *** core/reference_and_temp_sense_control.sv ***
// Control and status register for the fixed reference and temperature indicator
// Contract
// - Reference enable in bit 7 turns the fixed reference on or off.
// - Ready flag in bit 6 reads one only while the reference is usable.
// - On the standard-voltage variant the ready flag always reads one.
// - Temperature sense enable in bit 5 switches the indicator circuit.
// - Range select in bit 4: one picks high range, zero low range.
// - Comparator buffer gain bits 3-2: 11 x4, 10 x2, 01 x1, 00 off.
// - Converter buffer gain bits 1-0 decode the same way.
// - Temperature output goes internally to a converter channel, no pin.
// - Ready flag sets once reference and amplifier have settled.
//
// Added by the designer: the address map and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
`include "refctl_consts.svh"
module reference_and_temp_sense_control #(
   parameter bit STANDARD_VARIANT = 1'b0,
   parameter int unsigned SETTLE_CYCLES = `SETTLE_CYCLES
) (
   input wire logic clock, // 40 MHz core clock
   input wire logic rstn, // Async reset, active low
   input wire logic wb_cyc_i, // Wishbone cycle
   input wire logic wb_stb_i, // Wishbone strobe
   input wire logic wb_we_i, // Wishbone write enable
   input wire logic [3:0] wb_adr_i, // Byte address
   input wire logic [3:0] wb_sel_i, // Byte selects
   input wire logic [31:0] wb_dat_i, // Write data
   output logic [31:0] wb_dat_o, // Read data
   output logic wb_ack_o, // Acknowledge
   output logic wb_err_o, // Error on unmapped address
   output logic irq, // Level interrupt
   output logic reference_enable, // Fixed reference on
   output logic temp_sense_enable, // Temperature indicator on
   output logic temp_range_select, // 1 high range, 0 low range
   output logic [1:0] comparator_buffer_gain, // Comparator buffer gain
   output logic [1:0] converter_buffer_gain, // Converter buffer gain
   output logic temp_to_converter // Indicator routed to converter channel
);
   logic [7:0] ctrl_r;
   logic [7:0] ctrl_nxt;
   logic [`IRQ_BITS-1:0] status_r;
   logic [`IRQ_BITS-1:0] status_nxt;
   logic [`IRQ_BITS-1:0] mask_r;
   logic [`IRQ_BITS-1:0] mask_nxt;
   logic rdy_r;
   logic settled;
   refctl_pkg::ref_state_e state_r;
   refctl_pkg::ref_state_e state_nxt;

   wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   wire hit_ctrl = (wb_adr_i == `REF_CTRL_OFFSET);
   wire hit_stat = (wb_adr_i == `REF_IRQ_STATUS_OFFSET);
   wire hit_mask = (wb_adr_i == `REF_IRQ_MASK_OFFSET);
   wire hit_opt = (wb_adr_i == `REF_OPTIONS_OFFSET);
   wire mapped = hit_ctrl || hit_stat || hit_mask || hit_opt;
   wire wr = req && wb_we_i && mapped && wb_sel_i[0];
   wire wr_ctrl = wr && hit_ctrl;
   wire wr_stat = wr && hit_stat;
   wire wr_mask = wr && hit_mask;

   // Ready flag bit is kept from the live state, not from the write
   assign ctrl_nxt = wr_ctrl ? (wb_dat_i[7:0] & `REF_CTRL_WMASK) : ctrl_r;
   assign mask_nxt = wr_mask ? wb_dat_i[`IRQ_BITS-1:0] : mask_r;

   settle_timer #(
      .CYCLES(SETTLE_CYCLES)
   ) u_settle (
      .clock(clock),
      .rstn(rstn),
      .run(ctrl_r[`REF_EN_BIT]),
      .done(settled)
   );

   // Reference state: off, settling, ready
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         refctl_pkg::ref_off:
            if (ctrl_r[`REF_EN_BIT])
               state_nxt = refctl_pkg::ref_settling;
         refctl_pkg::ref_settling:
            if (!ctrl_r[`REF_EN_BIT])
               state_nxt = refctl_pkg::ref_off;
            else if (settled)
               state_nxt = refctl_pkg::ref_ready;
         refctl_pkg::ref_ready:
            if (!ctrl_r[`REF_EN_BIT])
               state_nxt = refctl_pkg::ref_off;
         default:
            state_nxt = refctl_pkg::ref_off;
      endcase
   end

   wire rdy_live = STANDARD_VARIANT ? 1'b1 : (state_nxt == refctl_pkg::ref_ready);
   wire rdy_rise = rdy_live && !rdy_r;
   wire rdy_fall = !rdy_live && rdy_r;

   // Hardware set wins over a write-one clear
   assign status_nxt = (status_r & ~(wr_stat ? wb_dat_i[`IRQ_BITS-1:0] : 2'b00))
                     | {rdy_fall, rdy_rise};

   wire [7:0] ctrl_view = {ctrl_r[7], rdy_r, ctrl_r[5:0]};
   wire [31:0] rd_data = hit_ctrl ? {24'h0, ctrl_view}
                       : hit_stat ? {30'h0, status_r}
                       : hit_mask ? {30'h0, mask_r}
                       : hit_opt ? {31'h0, STANDARD_VARIANT}
                       : 32'h0;

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         ctrl_r <= `REF_CTRL_RESET;
         state_r <= refctl_pkg::ref_off;
         // Standard variant starts ready, so no false rise follows reset
         rdy_r <= STANDARD_VARIANT;
         status_r <= 2'b00;
         mask_r <= 2'b00;
      end
      else
      begin
         ctrl_r <= ctrl_nxt;
         state_r <= state_nxt;
         rdy_r <= rdy_live;
         status_r <= status_nxt;
         mask_r <= mask_nxt;
      end
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end
      else
      begin
         wb_ack_o <= req && mapped;
         wb_err_o <= req && !mapped;
         wb_dat_o <= (req && mapped && !wb_we_i) ? rd_data : 32'h0;
      end
   end

   // Analog controls come straight from the register
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         reference_enable <= 1'b0;
         temp_sense_enable <= 1'b0;
         temp_range_select <= 1'b0;
         comparator_buffer_gain <= 2'b00;
         converter_buffer_gain <= 2'b00;
         temp_to_converter <= 1'b0;
         irq <= 1'b0;
      end
      else
      begin
         reference_enable <= ctrl_nxt[`REF_EN_BIT];
         temp_sense_enable <= ctrl_nxt[`TS_EN_BIT];
         temp_range_select <= ctrl_nxt[`TS_RNG_BIT];
         comparator_buffer_gain <= ctrl_nxt[`CMP_GAIN_HI:`CMP_GAIN_LO];
         converter_buffer_gain <= ctrl_nxt[`ADC_GAIN_HI:`ADC_GAIN_LO];
         temp_to_converter <= ctrl_nxt[`TS_EN_BIT];
         irq <= |(status_nxt & mask_nxt);
      end
   end
endmodule // reference_and_temp_sense_control
`default_nettype wire

// *** tb/refctl_checker.sv ***
// Assertion checker for the reference control register block
`timescale 1ns/100ps
`default_nettype none
module refctl_checker #(
   parameter bit STANDARD_VARIANT = 1'b0,
   parameter int unsigned SETTLE_CYCLES = 1000
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   input wire logic reference_enable,
   input wire logic temp_sense_enable,
   input wire logic temp_range_select,
   input wire logic [1:0] comparator_buffer_gain,
   input wire logic [1:0] converter_buffer_gain,
   input wire logic temp_to_converter
);
   wire tk = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   wire wr = tk && wb_we_i && wb_adr_i == 4'h0 && wb_sel_i[0];
   wire rd = tk && !wb_we_i && wb_adr_i == 4'h0;
   wire [6:0] ctl = {reference_enable, temp_sense_enable, temp_range_select,
      comparator_buffer_gain, converter_buffer_gain};
   int unsigned on_cnt_r;
   // Cycles the reference has been on, saturating
   always_ff @(posedge clock or negedge rstn)
      if (!rstn)
         on_cnt_r <= 0;
      else if (!reference_enable)
         on_cnt_r <= 0;
      else if (on_cnt_r < SETTLE_CYCLES + 16)
         on_cnt_r <= on_cnt_r + 1;
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   sequence s_rd_ctl;
      rd ##1 wb_ack_o;
   endsequence
   a_ctrl_write:
      assert property (wr |=> ctl == $past({wb_dat_i[7], wb_dat_i[5:0]})) else $error("ctrl");
   a_ctrl_hold:
      assert property (!wr |=> $stable(ctl)) else $error("hold");
   a_temp_route:
      assert property (wr |=> temp_to_converter == $past(wb_dat_i[5])) else $error("route");
   a_ready_read:
      assert property (s_rd_ctl |-> (STANDARD_VARIANT ? wb_dat_o[6] :
         !wb_dat_o[6] || on_cnt_r >= SETTLE_CYCLES)) else $error("ready early");
   a_ready_due:
      assert property (rd && on_cnt_r > SETTLE_CYCLES + 6 |=> wb_dat_o[6]) else $error("ready");
   a_answer_next:
      assert property (tk |=> wb_ack_o != wb_err_o) else $error("answer");
   a_err_unmapped:
      assert property (tk && wb_adr_i[1:0] != 2'h0 |=> wb_err_o) else $error("err");
   a_ack_pulse:
      assert property (wb_ack_o |=> !wb_ack_o && wb_dat_o == 32'h0) else $error("ack");
endmodule // refctl_checker
bind reference_and_temp_sense_control refctl_checker #(.STANDARD_VARIANT(STANDARD_VARIANT),
   .SETTLE_CYCLES(SETTLE_CYCLES)) i_refctl_checker (.*);
`default_nettype wire

// *** tb/reference_and_temp_sense_control_bench.sv ***
// Self-checking bench for the reference control register block
`timescale 1ns/100ps
`default_nettype none
module reference_and_temp_sense_control_bench;
   logic clock = 0, rstn = 0, cyc = 0, stb = 0, we = 0, ack, err, e, irq, t2c;
   logic [3:0] adr = 4'h0, sel = 4'h0;
   logic [31:0] dat = 32'h0, rdo, q, rdo2, q2;
   wire [6:0] ctl;
   int n_fail = 0, num_checks = 0;
   reference_and_temp_sense_control #(.SETTLE_CYCLES(4)) i_reference_and_temp_sense_control (
      .clock(clock), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdo), .wb_ack_o(ack),
      .wb_err_o(err), .irq(irq), .reference_enable(ctl[6]), .temp_sense_enable(ctl[5]),
      .temp_range_select(ctl[4]), .comparator_buffer_gain(ctl[3:2]),
      .converter_buffer_gain(ctl[1:0]), .temp_to_converter(t2c));
   // Standard-voltage variant shares the bus; only its read data is watched
   reference_and_temp_sense_control #(.STANDARD_VARIANT(1'b1), .SETTLE_CYCLES(4))
      i_reference_and_temp_sense_control_std (
      .clock(clock), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdo2), .wb_ack_o(),
      .wb_err_o(), .irq(), .reference_enable(), .temp_sense_enable(),
      .temp_range_select(), .comparator_buffer_gain(), .converter_buffer_gain(),
      .temp_to_converter());
   initial forever #12.5 clock = ~clock;
   task chk(input string n, input logic [31:0] x, input logic [31:0] g);
      num_checks++;
      if (g !== x)
      begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", n, x, g);
      end
   endtask
   // One classic cycle; holds the request until ack or err is sampled
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
      {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, s};
      do
         @(posedge clock);
      while (!ack && !err);
      q = rdo;
      q2 = rdo2;
      e = err;
      {cyc, stb} <= 2'b00;
      @(posedge clock);
   endtask
   task t_fields;
      logic [7:0] v;
      bus(0, 4'h0, 0, 4'hf);
      chk("ctrl reset", 0, q);
      chk("outputs reset", 0, {ctl, irq});
      chk("variant ready", 32'h40, q2);
      for (int i = 0; i < 4; i++)
      begin
         v = {2'b00, i[0], ~i[0], i[1:0], ~i[1:0]};
         bus(1, 4'h0, {24'h0, v | 8'h40}, 4'hf);
         chk("fields", {1'b0, v[5:0]}, ctl);
         chk("route", v[5], t2c);
         bus(1, 4'h0, 32'hff, 4'he);
         bus(0, 4'h0, 0, 4'hf);
         chk("readback", v, q);
      end
      $display("t_fields done");
   endtask
   task t_ready;
      int k;
      bus(1, 4'h8, 1, 4'hf);
      bus(1, 4'h0, 32'h80, 4'hf);
      chk("ref on", 1, ctl[6]);
      bus(0, 4'h0, 0, 4'hf);
      chk("settling", 0, q[6]);
      chk("variant settling", 32'hc0, q2);
      k = 0;
      while (!q[6] && k++ < 12)
         bus(0, 4'h0, 0, 4'hf);
      chk("ready", 1, q[6]);
      chk("irq rise", 1, irq);
      bus(1, 4'h4, 1, 4'hf);
      chk("irq clear", 0, irq);
      bus(0, 4'h0, 0, 4'hf);
      chk("ready held", 1, q[6]);
      bus(1, 4'h0, 0, 4'hf);
      bus(0, 4'h0, 0, 4'hf);
      chk("ref off", 0, q);
      chk("ref enable off", 0, ctl[6]);
      chk("variant off", 32'h40, q2);
      bus(0, 4'h4, 0, 4'hf);
      chk("fall status", 2, q);
      chk("fall masked", 0, irq);
      bus(1, 4'h4, 3, 4'hf);
      $display("t_ready done");
   endtask
   task t_unmapped;
      bus(1, 4'h1, 32'hff, 4'hf);
      chk("error", 1, e);
      bus(0, 4'h0, 0, 4'hf);
      chk("untouched", 0, q);
      $display("t_unmapped done");
   endtask
   task stop_test;
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (3) @(posedge clock);
      rstn <= 1;
      t_fields;
      t_ready;
      t_unmapped;
      stop_test;
   end
   initial
   begin
      #(25 * 3000);
      n_fail++;
      $display("[FAIL] watchdog expected finish seen timeout");
      stop_test;
   end
endmodule // reference_and_temp_sense_control_bench
`default_nettype wire
